//--- src/spmsp_pkg.sv
// Purpose: Constants and types for the byte-wide SPI master/slave port
// Assumes: One 250 MHz system clock, synchronous pin inputs
// Notes: Offsets are data-space addresses; I/O space sits 0x20 lower
// Overview of operation
// RULE_01: Slave: select low activates, output pin configurable
// RULE_02: Slave: select high resets logic, drops byte
// RULE_03: Master: select output pin is plain output
// RULE_04: Master: select input must be held high
// RULE_05: Select low as master: demote, set flag
// RULE_06: Software sets master bit again after fault
// RULE_07: Polarity and phase give four modes
// RULE_08: Polarity sets idle level and leading edge
// RULE_09: Phase picks sampling edge, setup on other
// RULE_10: Bit order one sends least bit first
// RULE_11: Nothing happens unless port enable set
// RULE_12: Rate bits divide clock by 4..128
// RULE_13: Double speed halves divisor, minimum two clocks
// RULE_14: Slave clock at most quarter system clock
// RULE_15: Byte done sets flag, raises enabled interrupt
// RULE_16: Flag cleared by vector or status-data sequence
// RULE_17: Write during transfer sets collision flag
// RULE_18: Data write starts, read returns receive buffer
// RULE_19: Registers at 0x4c..0x4e, I/O minus 0x20
// RULE_20: Master shifts eight bits then stops clock
// RULE_21: Receive double buffered, unread byte overwritten
// RULE_22: External clock phases exceed two system clocks
// RULE_23: Status bits five to one read zero

package spmsp_pkg;

  // ==========================================
  // Register map
  localparam logic [7:0] ADDR_CTRL = 8'h4c;
  localparam logic [7:0] ADDR_STAT = 8'h4d;
  localparam logic [7:0] ADDR_DATA = 8'h4e;
  localparam logic [7:0] IO_OFFSET = 8'h20;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic DBL_RESET = 1'b0;
  localparam logic [7:0] DATA_RESET = 8'h00;

  // ==========================================
  // Field positions
  localparam int B_IRQ_EN = 7;
  localparam int B_EN = 6;
  localparam int B_ORDER = 5;
  localparam int B_MASTER = 4;
  localparam int B_CPOL = 3;
  localparam int B_CPHA = 2;
  localparam int B_RATE_HI = 1;
  localparam int B_RATE_LO = 0;

  // ==========================================
  // Clock divisors and counts
  localparam logic [7:0] DIV_NORM [4] = '{8'h04, 8'h10, 8'h40, 8'h80};
  localparam logic [7:0] DIV_FAST [4] = '{8'h02, 8'h08, 8'h20, 8'h40};
  localparam logic [3:0] LAST_EDGE = 4'hf;
  localparam logic [2:0] LAST_SAMPLE = 3'h7;

  // ==========================================
  // Types
  typedef struct packed {
    logic sck;
    logic mosi;
    logic miso;
  } spmsp_pin_type;

  typedef struct packed {
    logic ss;
    logic sck;
    logic mosi;
    logic miso;
  } spmsp_dir_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_MRUN = 3'b010,
    ST_SLAVE = 3'b100
  } spmsp_state_type;

endpackage : spmsp_pkg

//--- src/spmsp_top.sv
// Purpose: SPI port, master or slave, with control, status and data registers
// Assumes: CPU strobes and pins synchronous to clock
// Notes: Receive side holds two bytes; overflow drops the oldest
`timescale 1ns/1ps

module spmsp_top
  import spmsp_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] cpu_addr,
  input wire logic cpu_io_space,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  input wire logic [7:0] cpu_wdata,
  output logic [7:0] cpu_rdata_r,
  input wire logic global_irq_enable,
  input wire logic irq_vector_ack,
  output logic irq_req_r,
  input wire spmsp_pin_type pin_in,
  input wire logic ss_in,
  input wire spmsp_dir_type pin_dir,
  output spmsp_pin_type pin_out_r,
  output spmsp_pin_type pin_oe_r
);

  // ==========================================
  // Declarations
  spmsp_state_type state_r;
  logic [7:0] ctrl_r;
  logic dbl_r, complete_flag_r, wcol_r, armed_r;
  logic [7:0] sr_r, sr_nxt;
  logic [7:0] ent0_r, ent1_r;
  logic [1:0] cnt_r;
  logic [7:0] div_cnt_r;
  logic [3:0] edge_cnt_r;
  logic [2:0] bit_cnt_r;
  logic sck_prev_r;
  logic [7:0] addr_eff, div_sel, half_m1, rx_word;
  logic enable, master, cpol, cpha, dord;
  logic ctrl_wr, stat_rd, data_wr, data_rd, data_acc;
  logic busy, start_m, slave_enter, mode_fault;
  logic m_tick, s_edge, lead, edge_ev, sample, setup, rx_bit;
  logic byte_done, push_ready, pop_valid, out_nxt;

  function automatic logic tx_of(input logic [7:0] v, input logic lsb_first);
    tx_of = lsb_first ? v[0] : v[7]; // RULE_10
  endfunction : tx_of

  // ==========================================
  // Decode
  assign addr_eff = cpu_io_space ? 8'(cpu_addr + IO_OFFSET) : cpu_addr; // RULE_19
  assign ctrl_wr = cpu_wr && addr_eff == ADDR_CTRL;
  assign stat_rd = cpu_rd && addr_eff == ADDR_STAT;
  assign data_wr = cpu_wr && addr_eff == ADDR_DATA;
  assign data_rd = cpu_rd && addr_eff == ADDR_DATA;
  assign data_acc = data_wr || data_rd;

  assign enable = ctrl_r[B_EN];
  assign master = ctrl_r[B_MASTER];
  assign cpol = ctrl_r[B_CPOL];
  assign cpha = ctrl_r[B_CPHA];
  assign dord = ctrl_r[B_ORDER];

  // Select input pulled low while master means another master took the bus
  assign mode_fault = enable && master && !pin_dir.ss && !ss_in; // RULE_04 RULE_05
  assign busy = state_r == ST_MRUN || (state_r == ST_SLAVE && bit_cnt_r != 3'h0); // RULE_17
  assign start_m = state_r == ST_IDLE && enable && master && data_wr && !mode_fault; // RULE_18 RULE_11
  assign slave_enter = state_r == ST_IDLE && enable && !master && !ss_in; // RULE_01

  // ==========================================
  // Edge generation
  assign div_sel = dbl_r ? DIV_FAST[ctrl_r[B_RATE_HI:B_RATE_LO]]
                         : DIV_NORM[ctrl_r[B_RATE_HI:B_RATE_LO]]; // RULE_12 RULE_13
  assign half_m1 = 8'((div_sel >> 1) - 8'h01);
  assign m_tick = state_r == ST_MRUN && div_cnt_r == half_m1;
  // Slave sees the pin directly; needs phases over two clocks to catch edges
  assign s_edge = state_r == ST_SLAVE && !ss_in && pin_in.sck != sck_prev_r; // RULE_22
  assign lead = (state_r == ST_MRUN) ? !edge_cnt_r[0] : (pin_in.sck != cpol); // RULE_08
  assign edge_ev = m_tick || s_edge;
  assign sample = edge_ev && (lead ^ cpha); // RULE_07 RULE_09
  assign setup = edge_ev && !(lead ^ cpha); // RULE_09
  assign rx_bit = (state_r == ST_MRUN) ? pin_in.miso : pin_in.mosi;
  assign sr_nxt = dord ? {rx_bit, sr_r[7:1]} : {sr_r[6:0], rx_bit}; // RULE_10
  // Phase 0 master ends on a setup edge with the byte already whole
  assign rx_word = sample ? sr_nxt : sr_r; // RULE_20
  assign byte_done = (m_tick && edge_cnt_r == LAST_EDGE)
                  || (state_r == ST_SLAVE && sample && bit_cnt_r == LAST_SAMPLE); // RULE_20
  assign push_ready = cnt_r != 2'h2;
  assign pop_valid = cnt_r != 2'h0;

  always_comb
  begin
    out_nxt = pin_out_r.mosi;
    if (data_wr && !busy && !cpha)
      out_nxt = tx_of(cpu_wdata, dord);
    else if (slave_enter && !cpha)
      out_nxt = tx_of(sr_r, dord);
    else if (setup)
      out_nxt = tx_of(sr_r, dord);
  end

  // ==========================================
  // State machine
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      state_r <= ST_IDLE;
    else
    begin
      unique case (state_r)
        ST_IDLE:
        begin
          if (start_m)
            state_r <= ST_MRUN; // RULE_20
          else if (slave_enter)
            state_r <= ST_SLAVE;
        end
        ST_MRUN:
        begin
          if (!enable || mode_fault || byte_done)
            state_r <= ST_IDLE; // RULE_05 RULE_11
        end
        ST_SLAVE:
        begin
          if (!enable || master || ss_in)
            state_r <= ST_IDLE; // RULE_02
        end
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  // ==========================================
  // Counters
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      div_cnt_r <= 8'h00;
      edge_cnt_r <= 4'h0;
      bit_cnt_r <= 3'h0;
      sck_prev_r <= 1'b0;
    end
    else
    begin
      sck_prev_r <= pin_in.sck;
      if (state_r != ST_MRUN || m_tick)
        div_cnt_r <= 8'h00;
      else
        div_cnt_r <= 8'(div_cnt_r + 8'h01);
      if (state_r != ST_MRUN)
        edge_cnt_r <= 4'h0;
      else if (m_tick)
        edge_cnt_r <= 4'(edge_cnt_r + 4'h1);
      if (state_r != ST_SLAVE || ss_in)
        bit_cnt_r <= 3'h0; // RULE_02
      else if (sample)
        bit_cnt_r <= 3'(bit_cnt_r + 3'h1);
    end
  end

  // ==========================================
  // Shift register
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      sr_r <= DATA_RESET;
    else if (data_wr && !busy)
      sr_r <= cpu_wdata; // RULE_18
    else if (sample)
      sr_r <= sr_nxt;
  end

  // ==========================================
  // Pin drive
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      pin_out_r <= '0;
      pin_oe_r <= '0;
    end
    else
    begin
      pin_out_r.mosi <= out_nxt;
      pin_out_r.miso <= out_nxt;
      if (state_r != ST_MRUN)
        pin_out_r.sck <= cpol; // RULE_08
      else if (m_tick)
        pin_out_r.sck <= !pin_out_r.sck;
      // Select pin is untouched here; as an output it is plain port logic
      pin_oe_r.sck <= enable && master && !mode_fault && pin_dir.sck; // RULE_03 RULE_05
      pin_oe_r.mosi <= enable && master && !mode_fault && pin_dir.mosi; // RULE_05
      pin_oe_r.miso <= enable && !master && !ss_in && pin_dir.miso; // RULE_01
    end
  end

  // ==========================================
  // Control and speed registers
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      ctrl_r <= CTRL_RESET;
      dbl_r <= DBL_RESET;
    end
    else
    begin
      if (ctrl_wr)
        ctrl_r <= cpu_wdata;
      // Fault beats a same-cycle write; software must set it again
      if (mode_fault)
        ctrl_r[B_MASTER] <= 1'b0; // RULE_05 RULE_06
      if (cpu_wr && addr_eff == ADDR_STAT)
        dbl_r <= cpu_wdata[0]; // RULE_13 RULE_23
    end
  end

  // ==========================================
  // Flags; a set in the clearing cycle wins
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      complete_flag_r <= 1'b0;
      wcol_r <= 1'b0;
      armed_r <= 1'b0;
    end
    else
    begin
      if (byte_done || mode_fault)
        complete_flag_r <= 1'b1; // RULE_15 RULE_05
      else if (irq_vector_ack || (armed_r && data_acc))
        complete_flag_r <= 1'b0; // RULE_16
      if (data_wr && busy)
        wcol_r <= 1'b1; // RULE_17
      else if (armed_r && data_acc)
        wcol_r <= 1'b0; // RULE_17
      if (stat_rd)
        armed_r <= complete_flag_r || wcol_r;
      else if (data_acc)
        armed_r <= 1'b0;
    end
  end

  // ==========================================
  // Receive buffer, two entries
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      ent0_r <= DATA_RESET;
      ent1_r <= DATA_RESET;
      cnt_r <= 2'h0;
    end
    else if (byte_done)
    begin
      if (cnt_r == 2'h0)
      begin
        ent0_r <= rx_word;
        cnt_r <= 2'h1;
      end
      else if (push_ready)
      begin
        ent1_r <= rx_word;
        cnt_r <= 2'h2;
      end
      else
      begin
        // Shifter cannot stall; the unread oldest byte is lost
        ent0_r <= ent1_r; // RULE_21
        ent1_r <= rx_word;
      end
    end
    else if (data_rd && cnt_r == 2'h2)
    begin
      ent0_r <= ent1_r; // RULE_21
      cnt_r <= 2'h1;
    end
    else if (data_rd && pop_valid)
      cnt_r <= 2'h0; // RULE_21
  end

  // ==========================================
  // Read data and interrupt request
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      cpu_rdata_r <= 8'h00;
      irq_req_r <= 1'b0;
    end
    else
    begin
      irq_req_r <= complete_flag_r && ctrl_r[B_IRQ_EN] && global_irq_enable; // RULE_15
      if (cpu_rd)
      begin
        unique case (addr_eff)
          ADDR_CTRL: cpu_rdata_r <= ctrl_r;
          ADDR_STAT: cpu_rdata_r <= {complete_flag_r, wcol_r, 5'h00, dbl_r}; // RULE_23
          ADDR_DATA: cpu_rdata_r <= ent0_r; // RULE_18
          default: cpu_rdata_r <= 8'h00;
        endcase
      end
    end
  end

  // ==========================================
  // Checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  fault_demote_a: assert property (mode_fault |=> !ctrl_r[B_MASTER] && complete_flag_r && state_r == ST_IDLE) // RULE_05
    else $error("mode fault did not demote");
  sck_release_a: assert property (mode_fault |=> !pin_oe_r.sck && !pin_oe_r.mosi) // RULE_05
    else $error("clock still driven after fault");
  ss_release_a: assert property (state_r == ST_SLAVE && ss_in |=> state_r == ST_IDLE ##1 bit_cnt_r == 3'h0) // RULE_02
    else $error("select high did not reset slave");
  miso_drive_a: assert property (pin_oe_r.miso |-> !$past(ss_in) && !$past(master)) // RULE_01
    else $error("slave output driven while deselected");
  enable_gate_a: assert property (!enable |=> state_r == ST_IDLE && !pin_oe_r.sck) // RULE_11
    else $error("port active while disabled");
  idle_level_a: assert property (state_r == ST_IDLE |=> pin_out_r.sck == $past(cpol)) // RULE_08
    else $error("clock idle level wrong");
  fast_byte_a: assert property (disable iff (rst || mode_fault || !enable || ctrl_wr || (cpu_wr && addr_eff == ADDR_STAT))
    start_m && dbl_r && ctrl_r[1:0] == 2'h0 |=> (state_r == ST_MRUN) [*8] ##8 byte_done ##1 state_r == ST_IDLE) // RULE_13
    else $error("fastest byte length wrong");
  done_flag_a: assert property (byte_done |=> complete_flag_r ##0 pop_valid) // RULE_15 RULE_20
    else $error("byte done did not set flag");
  irq_out_a: assert property (complete_flag_r && ctrl_r[B_IRQ_EN] && global_irq_enable |=> irq_req_r) // RULE_15
    else $error("interrupt request missing");
  wcol_set_a: assert property (data_wr && busy |=> wcol_r) // RULE_17
    else $error("collision not flagged");
  clear_seq_a: assert property (armed_r && data_acc && !byte_done && !mode_fault |=> !complete_flag_r) // RULE_16
    else $error("flag not cleared by sequence");
  rx_pop_a: assert property (data_rd && cnt_r == 2'h2 && !byte_done |=> cnt_r == 2'h1 && ent0_r == $past(ent1_r)) // RULE_21
    else $error("receive buffer pop wrong");

endmodule : spmsp_top

//--- verif/spmsp_partner.sv
// Purpose: Far-side SPI device model, slave or master
// Assumes: Bench calls its tasks; the bench resolves the shared lines
// Notes: Released lines toggle so a stale level never passes for data
`timescale 1ns/1ps

module spmsp_partner
(
  input wire logic clock,
  input wire logic sck_w,
  input wire logic mosi_w,
  input wire logic miso_w,
  output logic sck_d,
  output logic mosi_d,
  output logic miso_d,
  output logic ss_n
);
  logic sel_n;
  logic ph;
  logic lsb;
  logic [7:0] tx;
  logic [7:0] rx;
  int edges;

  initial
  begin
    sel_n = 1'b1;
    ss_n = 1'b1;
    sck_d = 1'b0;
    mosi_d = 1'b0;
    miso_d = 1'b0;
  end

  function automatic logic pick(input int i);
    return lsb ? tx[i] : tx[7-i];
  endfunction : pick

  // ==========================================
  // Slave role, answers at once
  always @(posedge clock)
    if (sel_n)
      miso_d <= ~miso_d;

  always @(sck_w)
  begin
    #0.5;
    if (!sel_n)
    begin
      edges++;
      if ((edges % 2 == 1) != ph)
        rx = lsb ? {mosi_w, rx[7:1]} : {rx[6:0], mosi_w};
      else if (edges < 16)
        miso_d = pick(edges / 2);
    end
  end

  task automatic select(input logic [7:0] t, input logic cpha, input logic first_lsb);
    tx = t;
    ph = cpha;
    lsb = first_lsb;
    edges = 0;
    sel_n = 1'b0;
    miso_d <= pick(0) ^ cpha;
  endtask : select

  task automatic deselect();
    sel_n = 1'b1;
  endtask : deselect

  // ==========================================
  // Master role, half period in system clocks
  task automatic drive(input logic [7:0] t, input logic cpol, input logic cpha, input logic first_lsb,
                       input int half, input int n, output logic [7:0] got);
    tx = t;
    lsb = first_lsb;
    got = 8'h00;
    sck_d <= cpol;
    repeat (half) @(posedge clock);
    ss_n <= 1'b0;
    mosi_d <= pick(0) ^ cpha;
    for (int e = 1; e <= n; e++)
    begin
      repeat (half) @(posedge clock);
      if ((e % 2 == 1) != cpha)
        got = lsb ? {miso_w, got[7:1]} : {got[6:0], miso_w};
      else if (e < 16)
        mosi_d <= pick(e / 2);
      sck_d <= ~sck_d;
    end
    repeat (half) @(posedge clock);
    ss_n <= 1'b1;
    mosi_d <= ~mosi_d;
  endtask : drive
endmodule : spmsp_partner

//--- verif/spi_master_slave_port_tb.sv
// Purpose: Self-checking bench for the SPI port
// Assumes: Partner model on the pins, CPU strobes from tasks
// Notes: Master rows first; slave, faults and reset by hand
`timescale 1ns/1ps

module spi_master_slave_port_tb
  import spmsp_pkg::*;
;
  typedef struct packed {
    logic [7:0] ctrl;
    logic dbl;
    logic [7:0] tx;
    logic [7:0] rx;
    logic [7:0] half;
  } spmsp_row_type;
  spmsp_row_type rows [8] = '{
    '{8'hd0, 1'b0, 8'h35, 8'h6a, 8'h02}, '{8'hf5, 1'b0, 8'h9c, 8'h41, 8'h08},
    '{8'hda, 1'b0, 8'h07, 8'he8, 8'h20}, '{8'hff, 1'b0, 8'hb2, 8'h5d, 8'h40},
    '{8'hf0, 1'b1, 8'h12, 8'hc8, 8'h01}, '{8'hd5, 1'b1, 8'h80, 8'h01, 8'h04},
    '{8'hfa, 1'b1, 8'h2b, 8'hd4, 8'h10}, '{8'hdf, 1'b1, 8'hf1, 8'h0e, 8'h20}};
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [7:0] cpu_addr = 8'h00;
  logic cpu_io_space = 1'b0;
  logic cpu_wr = 1'b0;
  logic cpu_rd = 1'b0;
  logic [7:0] cpu_wdata = 8'h00;
  logic [7:0] cpu_rdata_r;
  logic global_irq_enable = 1'b1;
  logic irq_vector_ack = 1'b0;
  logic irq_req_r;
  logic ss_low_n = 1'b1;
  spmsp_pin_type pin_in;
  spmsp_pin_type pin_out_r;
  spmsp_pin_type pin_oe_r;
  spmsp_dir_type pin_dir = '{1'b0, 1'b1, 1'b1, 1'b1};
  logic p_sck;
  logic p_mosi;
  logic p_miso;
  logic p_ss_n;
  logic [7:0] got;
  int bad_count = 0;
  int comparisons = 0;

  // ==========================================
  // Design, partner and shared lines
  assign pin_in.sck = pin_oe_r.sck ? pin_out_r.sck : p_sck;
  assign pin_in.mosi = pin_oe_r.mosi ? pin_out_r.mosi : p_mosi;
  assign pin_in.miso = pin_oe_r.miso ? pin_out_r.miso : p_miso;

  spmsp_top spmsp_top_i (.clock(clock), .rst(rst), .cpu_addr(cpu_addr), .cpu_io_space(cpu_io_space),
    .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata_r(cpu_rdata_r),
    .global_irq_enable(global_irq_enable), .irq_vector_ack(irq_vector_ack), .irq_req_r(irq_req_r),
    .pin_in(pin_in), .ss_in(p_ss_n & ss_low_n), .pin_dir(pin_dir), .pin_out_r(pin_out_r), .pin_oe_r(pin_oe_r));
  spmsp_partner spmsp_partner_i (.clock(clock), .sck_w(pin_in.sck), .mosi_w(pin_in.mosi),
    .miso_w(pin_in.miso), .sck_d(p_sck), .mosi_d(p_mosi), .miso_d(p_miso), .ss_n(p_ss_n));

  initial
    forever #2 clock = ~clock;

  // ==========================================
  // Tasks
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : wrap_up

  task automatic check(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    cpu_addr <= a;
    cpu_wdata <= d;
    cpu_wr <= 1'b1;
    @(posedge clock);
    cpu_wr <= 1'b0;
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    cpu_addr <= a;
    cpu_rd <= 1'b1;
    @(posedge clock);
    cpu_rd <= 1'b0;
    @(negedge clock);
    check(cpu_rdata_r, e);
  endtask : rdc

  task automatic wait_irq();
    int i;
    for (i = 0; i < 3000 && irq_req_r !== 1'b1; i++)
      @(negedge clock);
    check({7'h00, irq_req_r}, 8'h01);
    if (i == 3000)
      wrap_up();
  endtask : wait_irq

  // Cycles between the first two clock edges of a byte
  task automatic half_period(input logic [7:0] e);
    int n;
    logic s;
    s = pin_out_r.sck;
    for (n = 0; n < 300 && pin_out_r.sck === s; n++)
      @(negedge clock);
    s = pin_out_r.sck;
    for (n = 0; n < 300 && pin_out_r.sck === s; n++)
      @(negedge clock);
    check(n[7:0], e);
    if (n == 300)
      wrap_up();
  endtask : half_period

  // ==========================================
  // Main sequence
  initial
  begin
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    foreach (rows[k])
    begin
      wr(ADDR_STAT, {7'h00, rows[k].dbl});
      wr(ADDR_CTRL, rows[k].ctrl);
      repeat (2) @(posedge clock);
      check({7'h00, pin_out_r.sck}, {7'h00, rows[k].ctrl[B_CPOL]});
      spmsp_partner_i.select(rows[k].rx, rows[k].ctrl[B_CPHA], rows[k].ctrl[B_ORDER]);
      wr(ADDR_DATA, rows[k].tx);
      half_period(rows[k].half);
      wait_irq();
      check({7'h00, pin_out_r.sck}, {7'h00, rows[k].ctrl[B_CPOL]});
      spmsp_partner_i.deselect();
      check(spmsp_partner_i.rx, rows[k].tx);
      rdc(ADDR_STAT, {1'b1, 6'h00, rows[k].dbl});
      rdc(ADDR_DATA, rows[k].rx);
      rdc(ADDR_STAT, {7'h00, rows[k].dbl});
    end
    @(posedge clock) rst <= 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    rdc(ADDR_CTRL, CTRL_RESET);
    rdc(ADDR_STAT, 8'h00);
    wr(ADDR_STAT, 8'hff);
    rdc(ADDR_STAT, 8'h01);
    wr(ADDR_STAT, 8'h00);
    @(posedge clock) cpu_io_space <= 1'b1;
    wr(ADDR_CTRL - IO_OFFSET, 8'h2a);
    rdc(ADDR_CTRL - IO_OFFSET, 8'h2a);
    @(posedge clock) cpu_io_space <= 1'b0;
    rdc(ADDR_CTRL, 8'h2a);
    rdc(8'h4f, 8'h00);
    wr(ADDR_CTRL, 8'h90);
    wr(ADDR_DATA, 8'h55);
    repeat (40) @(posedge clock);
    check({7'h00, pin_out_r.sck}, 8'h00);
    rdc(ADDR_STAT, 8'h00);
    wr(ADDR_CTRL, 8'hed);
    wr(ADDR_DATA, 8'h4b);
    fork
      spmsp_partner_i.drive(8'hc6, 1'b1, 1'b1, 1'b1, 4, 16, got);
      begin
        repeat (30) @(posedge clock);
        check({5'h00, pin_oe_r}, 8'h01);
        wr(ADDR_DATA, 8'hff);
      end
    join
    wait_irq();
    check(got, 8'h4b);
    repeat (2) @(negedge clock);
    check({5'h00, pin_oe_r}, 8'h00);
    rdc(ADDR_STAT, 8'hc0);
    rdc(ADDR_DATA, 8'hc6);
    rdc(ADDR_STAT, 8'h00);
    spmsp_partner_i.drive(8'h5a, 1'b1, 1'b1, 1'b1, 4, 6, got);
    check({7'h00, irq_req_r}, 8'h00);
    rdc(ADDR_STAT, 8'h00);
    wr(ADDR_DATA, 8'h21);
    spmsp_partner_i.drive(8'h93, 1'b1, 1'b1, 1'b1, 9, 16, got);
    wait_irq();
    check(got, 8'h21);
    rdc(ADDR_STAT, 8'h80);
    rdc(ADDR_DATA, 8'h93);
    wr(ADDR_CTRL, 8'hd0);
    @(posedge clock) ss_low_n <= 1'b0;
    wait_irq();
    rdc(ADDR_CTRL, 8'hc0);
    check({5'h00, pin_oe_r}, 8'h01);
    @(posedge clock) global_irq_enable <= 1'b0;
    repeat (3) @(posedge clock);
    check({7'h00, irq_req_r}, 8'h00);
    global_irq_enable <= 1'b1;
    irq_vector_ack <= 1'b1;
    @(posedge clock) irq_vector_ack <= 1'b0;
    rdc(ADDR_STAT, 8'h00);
    @(posedge clock) ss_low_n <= 1'b1;
    wr(ADDR_CTRL, 8'hd0);
    rdc(ADDR_CTRL, 8'hd0);
    @(posedge clock) pin_dir.ss <= 1'b1;
    ss_low_n <= 1'b0;
    repeat (10) @(posedge clock);
    rdc(ADDR_CTRL, 8'hd0);
    check({7'h00, irq_req_r}, 8'h00);
    wrap_up();
  end
endmodule : spi_master_slave_port_tb
